// [design/ics_pkg.sv]
// Constants, types and helper functions shared by the sequencer core and its
// return-address stack.
// Assumes a single 20 MHz system clock and an active-low asynchronous reset.

package ics_pkg;

   // ---------------------------------------------------------------------
   // Timing and widths
   // ---------------------------------------------------------------------
   localparam int SYS_CLK_HZ = 20000000;
   localparam int CLKS_PER_CYCLE = 4;
   localparam int PC_W = 11;
   localparam int DM_AW = 8;
   localparam int STACK_DEPTH = 8;
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_READ = 2'h1;
   localparam logic [1:0] PH_EXEC = 2'h2;
   localparam logic [1:0] PH_COMMIT = 2'h3;

   // ---------------------------------------------------------------------
   // Reset values and fixed addresses
   // ---------------------------------------------------------------------
   localparam logic [PC_W-1:0] RESET_PC = 11'h000;
   localparam logic [7:0] RESET_ACC = 8'h00;
   localparam logic [DM_AW-1:0] PC_LOW_ADDR = 8'h06;

   // ---------------------------------------------------------------------
   // Instruction set, word layout and carriers
   // ---------------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP, OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X,
      OP_ADD_A_M, OP_ADD_A_X, OP_SUB_A_M, OP_SUB_A_X,
      OP_AND_A_M, OP_OR_A_M, OP_XOR_A_M, OP_AND_A_X,
      OP_OR_A_X, OP_XOR_A_X, OP_COMP_M, OP_COMPA_M,
      OP_INCR_M, OP_INCRA_M, OP_DECR_M, OP_DECRA_M,
      OP_ROTR_M, OP_ROTL_M, OP_ROTRC_M, OP_ROTLC_M,
      OP_SZ_M, OP_SZ_BIT, OP_SNZ_BIT, OP_JUMP,
      OP_CALL, OP_SUBR_EXIT, OP_INT_EXIT, OP_TABLE_RD
   } ics_op_t;

   // Branch targets are {bit_sel, operand}.
   typedef struct packed {
      ics_op_t op;
      logic [2:0] bit_sel;
      logic [7:0] operand;
   } ics_instr_t;

   typedef struct packed {
      logic we;
      logic [DM_AW-1:0] addr;
      logic [7:0] wdata;
   } ics_dm_req_t;

   typedef struct packed {
      logic carry;
      logic zero;
   } ics_flags_t;

   // Instructions that always need a second instruction cycle.
   function automatic logic ics_is_two_cycle(input ics_op_t op);
      return (op == OP_JUMP) || (op == OP_CALL) || (op == OP_SUBR_EXIT) ||
         (op == OP_INT_EXIT) || (op == OP_TABLE_RD);
   endfunction : ics_is_two_cycle

   // Conditional skip instructions.
   function automatic logic ics_is_skip(input ics_op_t op);
      return (op == OP_SZ_M) || (op == OP_SZ_BIT) || (op == OP_SNZ_BIT);
   endfunction : ics_is_skip

endpackage : ics_pkg

// [design/ics_stack.sv]
// Return-address stack: a small circular memory with registered read data.
// Assumes the caller never pushes and pops in the same cycle.
`timescale 1ns/10ps

module ics_stack #(
   parameter int DEPTH = ics_pkg::STACK_DEPTH,
   parameter int W = ics_pkg::PC_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic rd_req,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata
);
   import ics_pkg::*;

   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] sp_ff;
   logic [W-1:0] rdata_ff;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // Deeper nesting silently overwrites the oldest entry, as a ring does.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[sp_ff] <= wdata;
      end
   end

   // Pointer moves on push and pop only.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_ff <= '0;
      end else if (push) begin
         sp_ff <= sp_ff + PW'(1);
      end else if (pop) begin
         sp_ff <= sp_ff - PW'(1);
      end
   end

   // Top of stack is read ahead of the pop so data comes from a register.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (rd_req) begin
         rdata_ff <= mem[sp_ff - PW'(1)];
      end
   end

   assign rdata = rdata_ff;

endmodule : ics_stack

// [design/ics_core.sv]
// Instruction cycle sequencer with its accumulator datapath.
// Assumes program memory answers prog_addr within one system clock and data
// memory answers dm_req.addr combinationally on dm_rdata.
`timescale 1ns/10ps

module ics_core (
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic [ics_pkg::PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   output ics_pkg::ics_dm_req_t dm_req,
   input wire logic [7:0] dm_rdata,
   output logic [7:0] acc,
   output ics_pkg::ics_flags_t flags,
   output logic [7:0] table_high,
   output logic int_enable,
   output logic instr_tick,
   output logic extra_cycle
);
   import ics_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [1:0] phase_ff;
   logic [PC_W-1:0] fetch_ff;
   logic [PC_W-1:0] save_pc_ff;
   ics_instr_t ir_ff;
   logic bubble_ff;
   logic [7:0] acc_ff;
   ics_flags_t flags_ff;
   logic [7:0] opnd_ff;
   logic [7:0] res_ff;
   logic res_c_ff;
   logic wr_acc_ff;
   logic upd_c_ff;
   logic upd_z_ff;
   logic skip_ff;
   logic lowpc_wr_ff;
   ics_dm_req_t dm_req_ff;
   logic tab_pend_ff;
   logic [7:0] tab_lo_ff;
   logic [DM_AW-1:0] tab_dest_ff;
   logic [7:0] tab_hi_ff;
   logic int_en_ff;

   logic tick;
   logic exec_ph0;
   logic exec_ph1;
   logic exec_ph2;
   logic exec_commit;
   ics_op_t op;
   logic [8:0] nxt_res;
   logic nxt_wr_acc;
   logic nxt_wr_mem;
   logic nxt_upd_c;
   logic nxt_upd_z;
   logic nxt_skip;
   logic [PC_W-1:0] stack_top;
   logic push;
   logic pop;

   assign op = ir_ff.op;
   assign tick = (phase_ff == PH_COMMIT);
   assign exec_ph0 = (phase_ff == PH_ADDR) && !bubble_ff;
   assign exec_ph1 = (phase_ff == PH_READ) && !bubble_ff;
   assign exec_ph2 = (phase_ff == PH_EXEC) && !bubble_ff;
   assign exec_commit = tick && !bubble_ff;
   assign push = exec_commit && (op == OP_CALL);
   assign pop = exec_commit && ((op == OP_SUBR_EXIT) || (op == OP_INT_EXIT));

   // -----------------------------------------------------------------
   // Instruction cycle divider
   // -----------------------------------------------------------------
   // four-clock cycle: phase wraps every four system clocks.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= PH_ADDR;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // -----------------------------------------------------------------
   // Datapath: results formed from the accumulator, the operand and the carry
   // -----------------------------------------------------------------
   always_comb begin
      nxt_res = {1'b0, acc_ff};
      nxt_wr_acc = 1'b0;
      nxt_wr_mem = 1'b0;
      nxt_upd_c = 1'b0;
      nxt_upd_z = 1'b0;
      nxt_skip = 1'b0;
      case (op)
         OP_MOV_A_M: begin
            nxt_res = {1'b0, opnd_ff};
            nxt_wr_acc = 1'b1;
         end
         OP_MOV_M_A: nxt_wr_mem = 1'b1;
         OP_MOV_A_X: begin
            nxt_res = {1'b0, ir_ff.operand};
            nxt_wr_acc = 1'b1;
         end
         // carry and borrow: bit 8 of the 9-bit result.
         OP_ADD_A_M, OP_ADD_A_X: begin
            nxt_res = {1'b0, acc_ff} + {1'b0, (op == OP_ADD_A_M) ?
               opnd_ff : ir_ff.operand};
            {nxt_wr_acc, nxt_upd_c, nxt_upd_z} = 3'h7;
         end
         OP_SUB_A_M, OP_SUB_A_X: begin
            nxt_res = {1'b0, acc_ff} - {1'b0, (op == OP_SUB_A_M) ?
               opnd_ff : ir_ff.operand};
            {nxt_wr_acc, nxt_upd_c, nxt_upd_z} = 3'h7;
         end
         // logic via accumulator, zero on every logical result.
         OP_AND_A_M, OP_AND_A_X: begin
            nxt_res = {1'b0, acc_ff & ((op == OP_AND_A_M) ?
               opnd_ff : ir_ff.operand)};
            {nxt_wr_acc, nxt_upd_z} = 2'h3;
         end
         OP_OR_A_M, OP_OR_A_X: begin
            nxt_res = {1'b0, acc_ff | ((op == OP_OR_A_M) ?
               opnd_ff : ir_ff.operand)};
            {nxt_wr_acc, nxt_upd_z} = 2'h3;
         end
         OP_XOR_A_M, OP_XOR_A_X: begin
            nxt_res = {1'b0, acc_ff ^ ((op == OP_XOR_A_M) ?
               opnd_ff : ir_ff.operand)};
            {nxt_wr_acc, nxt_upd_z} = 2'h3;
         end
         OP_COMP_M, OP_COMPA_M: begin
            nxt_res = {1'b0, ~opnd_ff};
            nxt_wr_acc = (op == OP_COMPA_M);
            nxt_wr_mem = (op == OP_COMP_M);
            nxt_upd_z = 1'b1;
         end
         OP_INCR_M, OP_INCRA_M, OP_DECR_M, OP_DECRA_M: begin
            nxt_res = ((op == OP_INCR_M) || (op == OP_INCRA_M)) ?
               {1'b0, opnd_ff + 8'h01} : {1'b0, opnd_ff - 8'h01};
            nxt_wr_acc = (op == OP_INCRA_M) || (op == OP_DECRA_M);
            nxt_wr_mem = (op == OP_INCR_M) || (op == OP_DECR_M);
            nxt_upd_z = 1'b1;
         end
         OP_ROTR_M: begin
            nxt_res = {1'b0, opnd_ff[0], opnd_ff[7:1]};
            nxt_wr_mem = 1'b1;
         end
         OP_ROTL_M: begin
            nxt_res = {1'b0, opnd_ff[6:0], opnd_ff[7]};
            nxt_wr_mem = 1'b1;
         end
         OP_ROTRC_M: begin
            nxt_res = {opnd_ff[0], flags_ff.carry, opnd_ff[7:1]};
            {nxt_wr_mem, nxt_upd_c} = 2'h3;
         end
         OP_ROTLC_M: begin
            nxt_res = {opnd_ff[7], opnd_ff[6:0], flags_ff.carry};
            {nxt_wr_mem, nxt_upd_c} = 2'h3;
         end
         // tests on a byte or a single bit.
         OP_SZ_M: nxt_skip = (opnd_ff == 8'h00);
         OP_SZ_BIT: nxt_skip = !opnd_ff[ir_ff.bit_sel];
         OP_SNZ_BIT: nxt_skip = opnd_ff[ir_ff.bit_sel];
         default: ;
      endcase
   end

   // -----------------------------------------------------------------
   // Phase pipeline inside one instruction cycle
   // -----------------------------------------------------------------
   // Address out, operand in, result formed, then write strobe on phase 3.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dm_req_ff <= '0;
         opnd_ff <= 8'h00;
      end else begin
         if (phase_ff == PH_ADDR) begin
            dm_req_ff.addr <= bubble_ff ? tab_dest_ff : ir_ff.operand;
         end
         // Reads of the counter low byte return this instruction's address.
         if (exec_ph1) begin
            opnd_ff <= (dm_req_ff.addr == PC_LOW_ADDR) ?
               8'(fetch_ff - 11'h001) : dm_rdata;
         end
         if (exec_ph2) begin
            dm_req_ff.we <= nxt_wr_mem &&
               (dm_req_ff.addr != PC_LOW_ADDR);
            dm_req_ff.wdata <= nxt_res[7:0];
         end else if (phase_ff == PH_EXEC) begin
            dm_req_ff.we <= tab_pend_ff;
            dm_req_ff.wdata <= tab_lo_ff;
         end else if (tick) begin
            dm_req_ff.we <= 1'b0;
         end
      end
   end

   // Result and control latched once the operand is stable.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {res_ff, res_c_ff, wr_acc_ff, upd_c_ff, upd_z_ff} <= '0;
         {skip_ff, lowpc_wr_ff} <= 2'h0;
      end else if (exec_ph2) begin
         res_ff <= nxt_res[7:0];
         res_c_ff <= nxt_res[8];
         wr_acc_ff <= nxt_wr_acc;
         upd_c_ff <= nxt_upd_c;
         upd_z_ff <= nxt_upd_z;
         skip_ff <= nxt_skip;
         // destination is the counter low byte.
         lowpc_wr_ff <= nxt_wr_mem && (dm_req_ff.addr == PC_LOW_ADDR);
      end else if (tick) begin
         {wr_acc_ff, upd_c_ff, upd_z_ff, skip_ff, lowpc_wr_ff} <= 5'h00;
      end
   end

   // Accumulator and flags commit at the end of the cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= RESET_ACC;
         flags_ff <= '0;
      end else if (exec_commit) begin
         if (wr_acc_ff) begin
            acc_ff <= res_ff;
         end
         if (upd_c_ff) begin
            flags_ff.carry <= res_c_ff;
         end
         if (upd_z_ff) begin
            flags_ff.zero <= (res_ff == 8'h00);
         end
      end
   end

   // -----------------------------------------------------------------
   // Fetch and flow control
   // -----------------------------------------------------------------
   // The table word is fetched in place of the next instruction, so the
   // sequential fetch address is parked and restored at commit.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_ff <= RESET_PC;
         save_pc_ff <= RESET_PC;
         ir_ff <= '0;
         bubble_ff <= 1'b1;
      end else if (exec_ph0 && (op == OP_TABLE_RD)) begin
         save_pc_ff <= fetch_ff;
         fetch_ff <= {fetch_ff[PC_W-1:8], acc_ff};
      end else if (tick) begin
         ir_ff <= ics_instr_t'(prog_data);
         bubble_ff <= 1'b0;
         fetch_ff <= fetch_ff + 11'h001;
         if (exec_commit) begin
            // redirect: the word fetched this cycle is dropped.
            // extra cycle for long and skipping instructions.
            bubble_ff <= ics_is_two_cycle(op) || lowpc_wr_ff || skip_ff;
            case (op)
               // jump and call load the target; only call saves a return address.
               OP_JUMP, OP_CALL: fetch_ff <= {ir_ff.bit_sel, ir_ff.operand};
               OP_SUBR_EXIT, OP_INT_EXIT: fetch_ff <= stack_top;
               OP_TABLE_RD: fetch_ff <= save_pc_ff;
               default: begin
                  // jump to the written low byte.
                  if (lowpc_wr_ff) begin
                     fetch_ff <= {fetch_ff[PC_W-1:8], res_ff};
                  end
               end
            endcase
         end
      end
   end

   // Table result and the interrupt enable left by an interrupt exit.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {tab_pend_ff, tab_lo_ff, tab_hi_ff, int_en_ff} <= '0;
         tab_dest_ff <= '0;
      end else if (tick) begin
         tab_pend_ff <= exec_commit && (op == OP_TABLE_RD);
         if (exec_commit && (op == OP_TABLE_RD)) begin
            tab_lo_ff <= prog_data[7:0];
            tab_hi_ff <= prog_data[15:8];
            tab_dest_ff <= ir_ff.operand;
         end
         if (exec_commit && (op == OP_INT_EXIT)) begin
            int_en_ff <= 1'b1;
         end
      end
   end

   // call saves the address after itself.
   ics_stack #(
      .DEPTH(STACK_DEPTH),
      .W(PC_W)
   ) u_stack (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .push(push),
      .pop(pop),
      .rd_req(exec_ph1),
      .wdata(fetch_ff),
      .rdata(stack_top)
   );

   assign prog_addr = fetch_ff;
   assign dm_req = dm_req_ff;
   assign acc = acc_ff;
   assign flags = flags_ff;
   assign table_high = tab_hi_ff;
   assign int_enable = int_en_ff;
   assign instr_tick = tick;
   assign extra_cycle = bubble_ff;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_cycle_len: assert property (
      instr_tick |=> !instr_tick [*3] ##1 instr_tick)
      else $error("Instruction cycle is not four clocks.");
   chk_two_cycle: assert property (
      exec_commit && ics_is_two_cycle(op) |=>
      extra_cycle [*4] ##1 !extra_cycle)
      else $error("Two-cycle instruction did not idle one cycle.");
   chk_lowpc_jump: assert property (
      exec_commit && lowpc_wr_ff |=>
      extra_cycle && prog_addr[7:0] == $past(res_ff))
      else $error("Counter low write did not redirect.");
   chk_skip_time: assert property (
      exec_commit && ics_is_skip(op) |=> extra_cycle == $past(skip_ff))
      else $error("Skip timing wrong.");
   chk_jump_target: assert property (
      exec_commit && op == OP_JUMP |=>
      prog_addr == {$past(ir_ff.bit_sel), $past(ir_ff.operand)} &&
      $stable(u_stack.sp_ff))
      else $error("Jump target wrong.");
   chk_add_carry: assert property (
      exec_commit && op == OP_ADD_A_M |=>
      {flags.carry, acc} == {1'b0, $past(acc_ff)} + {1'b0, $past(opnd_ff)})
      else $error("Add carry wrong.");
   chk_step_one: assert property (
      exec_commit && op == OP_INCRA_M |=> acc == 8'($past(opnd_ff) + 8'h01))
      else $error("Increment step wrong.");
   chk_logic_zero: assert property (
      exec_commit && (op == OP_AND_A_M || op == OP_XOR_A_X) |=>
      flags.zero == (acc == 8'h00))
      else $error("Zero flag wrong after logic.");
   chk_rot_carry: assert property (
      exec_commit && op == OP_ROTRC_M |=> flags.carry == $past(opnd_ff[0]))
      else $error("Rotate carry wrong.");
   chk_bubble_idle: assert property (
      extra_cycle && !tab_pend_ff |-> !dm_req.we)
      else $error("Extra cycle wrote data memory.");

   cov_jump: cover property (exec_commit && op == OP_JUMP);
   cov_skip: cover property (exec_commit && skip_ff);
   cov_call_ret: cover property (exec_commit && op == OP_SUBR_EXIT);
   cov_table: cover property (tab_pend_ff && dm_req.we);

endmodule : ics_core

// [sim/testbench.sv]
// Self-checking bench for the instruction cycle sequencer core.
// Assumes the core alone; program and data memories are modelled here.
`timescale 1ns/10ps

module testbench;
   import ics_pkg::*;

   // ------------------------------------------------------------
   // Signals and memories
   // ------------------------------------------------------------
   localparam int LIMIT = 20000;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [PC_W-1:0] prog_addr;
   logic [15:0] prog_data;
   ics_dm_req_t dm_req;
   logic [7:0] dm_rdata;
   logic [7:0] acc;
   ics_flags_t flags;
   logic [7:0] table_high;
   logic int_enable;
   logic instr_tick;
   logic extra_cycle;
   logic [15:0] prog [0:2047];
   logic [7:0] dmem [0:255];
   logic [7:0] ac [0:7];
   logic ex [0:7];
   logic [7:0] pa [0:7];
   logic cy [0:7];
   logic zf [0:7];
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   integer seed = 32'h1CE0AE1B;

   ics_core ics_core_i (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .prog_addr(prog_addr),
      .prog_data(prog_data),
      .dm_req(dm_req),
      .dm_rdata(dm_rdata),
      .acc(acc),
      .flags(flags),
      .table_high(table_high),
      .int_enable(int_enable),
      .instr_tick(instr_tick),
      .extra_cycle(extra_cycle)
   );

   // Clock of 50 ns period.
   always #25 sys_clk = ~sys_clk;

   // Memories answer without delay, so no read waits are modelled.
   assign prog_data = prog[prog_addr];
   assign dm_rdata = dmem[dm_req.addr];

   // Data memory takes the one-clock write strobe.
   always @(posedge sys_clk) begin
      if (dm_req.we === 1'b1) begin
         dmem[dm_req.addr] <= dm_req.wdata;
      end
   end

   // A hang is cut short here and counted as a mismatch.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // Tasks and reference functions
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   // Loads a short program around instruction i1, resets mid-run and
   // records state after each of eight instruction cycles.
   task automatic run(input logic [15:0] i1, input logic [7:0] a,
                      input logic [7:0] mv, input logic [15:0] w41);
      int k;
      int g;
      prog[0] = {OP_MOV_A_X, 3'h0, a};
      prog[1] = i1;
      prog[2] = {OP_MOV_A_X, 3'h0, 8'h11};
      prog[3] = {OP_MOV_A_X, 3'h0, 8'h22};
      prog[11'h040] = {OP_MOV_A_X, 3'h0, 8'h44};
      prog[11'h041] = w41;
      dmem[6] = 8'h5A;
      dmem[i1[7:0]] = mv;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (k = 0; k < 8; k++) begin
         g = 0;
         do begin
            @(negedge sys_clk);
            g++;
         end while (instr_tick !== 1'b1 && g < 8);
         check(8'(g), 8'h04);
         ex[k] = extra_cycle;
         pa[k] = prog_addr[7:0];
         @(posedge sys_clk);
         #1;
         ac[k] = acc;
         cy[k] = flags.carry;
         zf[k] = flags.zero;
      end
   endtask : run

   // Returns {zero checked, acc, memory byte, carry, zero}.
   function automatic logic [18:0] model(input ics_op_t op,
                                         input logic [7:0] a, b);
      logic [7:0] r;
      logic [7:0] m;
      logic c;
      logic z;
      logic zm;
      r = a;
      m = b;
      c = 1'b0;
      z = 1'b0;
      zm = 1'b1;
      case (op)
         OP_MOV_A_M, OP_MOV_A_X: r = b;
         OP_MOV_M_A: m = a;
         OP_ADD_A_M, OP_ADD_A_X: begin
            {c, r} = {1'b0, a} + {1'b0, b};
            zm = 1'b0;
         end
         OP_SUB_A_M, OP_SUB_A_X: begin
            {c, r} = {1'b0, a} - {1'b0, b};
            zm = 1'b0;
         end
         OP_AND_A_M, OP_AND_A_X: r = a & b;
         OP_OR_A_M, OP_OR_A_X: r = a | b;
         OP_XOR_A_M, OP_XOR_A_X: r = a ^ b;
         OP_COMP_M: m = ~b;
         OP_COMPA_M: r = ~b;
         OP_INCR_M: m = b + 8'h01;
         OP_INCRA_M: r = b + 8'h01;
         OP_DECR_M: m = b - 8'h01;
         OP_DECRA_M: r = b - 8'h01;
         OP_ROTR_M: m = {b[0], b[7:1]};
         OP_ROTL_M: m = {b[6:0], b[7]};
         OP_ROTRC_M: {m, c} = {1'b0, b};
         OP_ROTLC_M: {c, m} = {b, 1'b0};
         default: r = a;
      endcase
      if (op inside {[OP_AND_A_M:OP_XOR_A_X], OP_COMPA_M, OP_INCRA_M,
                     OP_DECRA_M}) begin
         z = (r == 8'h00);
      end
      if (op inside {OP_COMP_M, OP_INCR_M, OP_DECR_M}) begin
         z = (m == 8'h00);
      end
      return {zm, r, m, c, z};
   endfunction : model

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      ics_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] ad;
      logic [18:0] e;
      logic [15:0] tw;
      logic [2:0] bs;
      logic tk;
      for (int i = 0; i < 2048; i++) prog[i] = 16'h0000;
      for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
      repeat (12) @(posedge sys_clk);
      for (int it = 0; it < 4; it++) begin
         for (int o = 1; o < 24; o++) begin
            op = ics_op_t'(o);
            a = 8'($random(seed));
            b = 8'($random(seed));
            ad = {3'h1, 5'($random(seed))};
            if (it == 0) a = 8'hFF;
            if (it < 2) b = 8'h01;
            if (it == 1) a = 8'h00;
            if (op inside {OP_MOV_A_X, OP_ADD_A_X, OP_SUB_A_X,
                           [OP_AND_A_X:OP_XOR_A_X]}) ad = b;
            run({op, 3'h0, ad}, a, b, {OP_MOV_A_X, 3'h0, 8'h45});
            e = model(op, a, b);
            check(ac[2], e[17:10]);
            check(dmem[ad], e[9:2]);
            check({7'h0, cy[2]}, {7'h0, e[1]});
            if (e[18]) check({7'h0, zf[2]}, {7'h0, e[0]});
            check({7'h0, ex[3]}, 8'h00);
            check(ac[3], 8'h11);
         end
      end
      run({OP_JUMP, 3'h0, 8'h40}, 8'h77, 8'h00, {OP_MOV_A_X, 3'h0, 8'h45});
      check({7'h0, ex[3]}, 8'h01);
      check(ac[3], 8'h77);
      check(ac[4], 8'h44);
      check(pa[4], 8'h41);
      check({7'h0, int_enable}, 8'h00);
      for (int x = 0; x < 2; x++) begin
         op = x ? OP_INT_EXIT : OP_SUBR_EXIT;
         run({OP_CALL, 3'h0, 8'h40}, 8'h33, 8'h00, {op, 11'h000});
         check(ac[4], 8'h44);
         check({7'h0, ex[6]}, 8'h01);
         check(ac[7], 8'h11);
         check({7'h0, int_enable}, {7'h0, x[0]});
      end
      // counter low byte write redirects fetch.
      run({OP_MOV_M_A, 3'h0, PC_LOW_ADDR}, 8'h40, 8'h5A, 16'h0000);
      check({7'h0, ex[3]}, 8'h01);
      check(ac[4], 8'h44);
      check(dmem[6], 8'h5A);
      check(pa[3], 8'h40);
      // table read fetches from {upper bits, acc}.
      tw = 16'($random(seed));
      prog[11'h050] = tw;
      run({OP_TABLE_RD, 3'h0, 8'h30}, 8'h50, 8'h00, 16'h0000);
      check({7'h0, ex[3]}, 8'h01);
      check(ac[4], 8'h11);
      check(table_high, tw[15:8]);
      check(dmem[8'h30], tw[7:0]);
      check(pa[2], 8'h50);
      for (int i = 0; i < 12; i++) begin
         op = ics_op_t'(24 + i % 3);
         b = (i < 3) ? 8'h00 : 8'($random(seed));
         bs = 3'($random(seed));
         tk = (op == OP_SZ_M) ? (b == 8'h00) :
              (op == OP_SZ_BIT) ? ~b[bs] : b[bs];
         run({op, bs, 8'h38}, 8'h66, b, 16'h0000);
         check({7'h0, ex[3]}, {7'h0, tk});
         check(tk ? ac[4] : ac[3], tk ? 8'h22 : 8'h11);
      end
      finish_test();
   end
endmodule : testbench
